// ===== rtl/sadc_pkg.sv
/*
  Package for the converter sequencer: register offsets, field positions,
  reset values and timing counts shared by the design and its bench.
  Assumes a byte-addressed plain register port with 32-bit data.
*/
package sadc_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] SADC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] SADC_SMP_OFS    = 8'h04;
  localparam logic [7:0] SADC_CHSEL_OFS  = 8'h08;
  localparam logic [7:0] SADC_SLOW_OFS   = 8'h0C;
  localparam logic [7:0] SADC_WIN_OFS    = 8'h10;
  localparam logic [7:0] SADC_STAT_OFS   = 8'h14;
  localparam logic [7:0] SADC_DATA_OFS   = 8'h18;
  localparam logic [7:0] SADC_BUFDIS_OFS = 8'h1C;

  // Control register fields
  localparam int SADC_CTRL_ON     = 0;
  localparam int SADC_CTRL_START  = 1;
  localparam int SADC_CTRL_CONTINUOUS_ENABLE   = 2;
  localparam int SADC_CTRL_DMADIS = 3;
  localparam int SADC_CTRL_DIV2   = 4;
  localparam int SADC_CTRL_RES    = 5;   // Two bits: 00=12, 01=10, 10=8, 11=6
  localparam int SADC_CTRL_TRIG   = 7;   // Two bits: 00=sw, 01=timer, 10=pin
  localparam int SADC_CTRL_EOCIE  = 9;
  localparam int SADC_CTRL_WINIE  = 10;
  localparam int SADC_CTRL_OVRIE  = 11;
  localparam int SADC_CTRL_VREFEN = 12;
  localparam int SADC_CTRL_TSEN   = 13;
  localparam int SADC_CTRL_WINCH  = 16;  // Five bits: monitored channel
  localparam int SADC_CTRL_WINEN  = 21;

  // Status fields (flags write one to clear; busy is read-only)
  localparam int SADC_ST_EOC  = 0;
  localparam int SADC_ST_WIN  = 1;
  localparam int SADC_ST_OVR  = 2;
  localparam int SADC_ST_BUSY = 3;

  // Channel map
  localparam int SADC_NCH      = 27;
  localparam int SADC_CH_VREF  = 25;
  localparam int SADC_CH_TEMP  = 26;

  // Sampling range in converter cycles
  localparam int SADC_SMP_MIN = 4;
  localparam int SADC_SMP_MAX = 384;
  localparam logic [8:0] SADC_SMP_RST = 9'h004;

  // Stabilisation interval, kept by software
  localparam int SADC_STAB_NS  = 3000;
  localparam int SADC_CLK_MHZ  = 50;
  localparam int SADC_STAB_CYC = (SADC_STAB_NS * SADC_CLK_MHZ + 999) / 1000;

endpackage : sadc_pkg

// ===== rtl/sadc_sequencer.sv
/*
  Successive-approximation converter sequencer: register port, channel
  sequencing, sampling timer, bit-by-bit approximation and events.
  Assumes an analog comparator answering cmpHigh in the same converter
  cycle, and a DMA engine that pulses dmaAck when it takes the result.
*/
// The address map and the strobed register port were decided locally.
// Overview of operation
// R1: Steps per conversion equal resolution bits.
// R2: Decide bits from MSB down to LSB.
// R3: Resolutions 6, 8, 10 and 12 bits.
// R4: Converter clock is system clock over 1 or 2.
// R5: One approximation step per converter cycle.
// R6: Sampling lasts 4 to 384 converter cycles.
// R7: Software waits stabilisation time after enabling.
// R8: 25 pin channels plus two internal.
// R9: Internal reference is channel 25.
// R10: Per-pin digital input buffer disable.
// R11: Internal sources reset disabled, enabled by software.
// R12: Fast and slow groups, own sampling times.
// R13: Trigger from software, timer or pin.
// R14: Out-of-window result sets flag, optional interrupt.
// R15: End-of-conversion when result register loads.
// R16: Overrun when result unread by DMA.
// R17: DMA request for every result.
// R18: Single mode converts once, then stops.
// R19: Continuous mode proceeds through sequence automatically.
// R20: Scan mode converts every selected channel; the code skips a selected internal channel whose source is switched off.
// R21: Single without DMA converts highest selected only.
// R22: Continuous raises end-of-conversion per sequence.
// R23: Clearing continuous finishes sequence then stops; with DMA disabled the code stops at the next channel boundary.
// R24: Software starts via start bit after stabilisation.
// R25: Triggers ignored while busy.
// R26: Flags sticky until cleared; interrupt ORs enabled.
// R27: Result register stable until next result.
`timescale 1ns/1ns
`default_nettype none

module sadc_sequencer
  import sadc_pkg::*;
#(
  parameter int RES_MAX = 12
) (
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // Trigger inputs
  input  wire logic        timerTrig,
  input  wire logic        trigPin,
  // Analog front end
  input  wire logic        cmpHigh,
  output logic      [4:0]  muxSel,
  output logic             sampleOn,
  output logic      [11:0] dacCode,
  output logic             vrefEnable,
  output logic             tempEnable,
  output logic      [24:0] pinBufDisable,
  // DMA and interrupt
  output logic             dmaReq,
  input  wire logic        dmaAck,
  output logic             irq
);

  // Elaboration check: the trial code, masks and result path are 12 bits wide
  if (RES_MAX != 12) begin : g_resCheck
    $error("sadc_sequencer: only 12-bit core supported");
  end

  typedef enum logic [1:0] {
    SADC_IDLE   = 2'b00,
    SADC_SAMPLE = 2'b01,
    SADC_CONV   = 2'b10,
    SADC_NEXT   = 2'b11
  } sadc_state_t;

  // Registers
  logic [31:0] ctrl_r;
  logic [8:0]  smpFast_r, smpSlow_r;
  logic [26:0] chSel_r, slowGrp_r;
  logic [11:0] winLo_r, winHi_r;
  logic [24:0] bufDis_r;
  logic [2:0]  flags_r;
  logic [11:0] data_r;
  logic [31:0] rdata_r;
  sadc_state_t state_r;
  logic [4:0]  ch_r;
  logic [8:0]  cnt_r;
  logic [3:0]  bit_r;
  logic [11:0] sar_r;
  logic        unread_r;
  logic        divTick_r;
  logic        dmaReq_r, irq_r, sampleOn_r;
  logic [2:0]  pinSync_r;
  logic        pinLvl_r, tmrPrev_r;

  // Field decode
  wire       convOn  = ctrl_r[SADC_CTRL_ON];
  wire       contEn  = ctrl_r[SADC_CTRL_CONTINUOUS_ENABLE];
  wire       dmaDis  = ctrl_r[SADC_CTRL_DMADIS];
  wire [1:0] resSel  = ctrl_r[SADC_CTRL_RES +: 2];
  wire [1:0] trigSel = ctrl_r[SADC_CTRL_TRIG +: 2];
  wire [4:0] winCh   = ctrl_r[SADC_CTRL_WINCH +: 5];
  wire       wrCtrl  = regWr && regAddr == SADC_CTRL_OFS;
  wire       wrStat  = regWr && regAddr == SADC_STAT_OFS;
  wire       busy    = state_r != SADC_IDLE;

  // Resolution to number of steps: lower resolution, fewer cycles
  wire [3:0] nBits = 4'd12 - {resSel, 1'b0}; // R3 R1

  // Converter tick: every cycle, or every second cycle when dividing
  wire       tick = ~ctrl_r[SADC_CTRL_DIV2] | divTick_r; // R4
  // The divider restarts before each sampling phase, so a phase always spans whole
  // converter cycles instead of losing half a cycle to a free-running phase
  wire       divHold = state_r == SADC_IDLE || state_r == SADC_NEXT;

  // Pin trigger edges count once the second and third stages agree
  wire       pinStable = pinSync_r[2] == pinSync_r[1];
  wire       pinEdge   = pinStable && pinSync_r[2] != pinLvl_r;
  wire       tmrEdge   = timerTrig & ~tmrPrev_r;
  wire       swStart   = wrCtrl && regWdata[SADC_CTRL_START];
  wire       trigSw    = trigSel == 2'b00 && swStart;
  wire       trigAny   = trigSw | (trigSel == 2'b01 && tmrEdge)
                         | (trigSel == 2'b10 && pinEdge); // R13 R24

  // Find next selected channel from a position: lowest at or above 'from'
  function automatic logic [5:0] sadc_next(input logic [26:0] sel,
                                           input logic [5:0] from);
    logic [5:0] res;
    res = 6'h3F;
    for (int i = SADC_NCH - 1; i >= 0; i--) begin
      if (sel[i] && i[5:0] >= from) begin
        res = i[5:0];
      end
    end
    return res;
  endfunction : sadc_next

  // Highest selected channel, used for single conversions without DMA
  function automatic logic [5:0] sadc_top(input logic [26:0] sel);
    logic [5:0] res;
    res = 6'h3F;
    for (int i = 0; i < SADC_NCH; i++) begin
      if (sel[i]) begin
        res = i[5:0];
      end
    end
    return res;
  endfunction : sadc_top

  // Internal channels only usable once their source is switched on
  wire [26:0] chUsable = {ctrl_r[SADC_CTRL_TSEN], ctrl_r[SADC_CTRL_VREFEN],
                          25'h1FF_FFFF} & chSel_r; // R8 R9 R11
  wire        oneShot  = ~contEn & dmaDis; // R21
  wire [5:0]  firstCh  = oneShot ? sadc_top(chUsable)
                                 : sadc_next(chUsable, 6'd0); // R20
  wire [5:0]  nextCh   = oneShot ? 6'h3F
                                 : sadc_next(chUsable, {1'b0, ch_r} + 6'd1);
  wire [5:0]  restart  = sadc_next(chUsable, 6'd0);
  wire [8:0]  smpLen   = slowGrp_r[ch_r] ? smpSlow_r : smpFast_r; // R12

  // Approximation bit and trial code
  wire [11:0] bitMask  = 12'h001 << bit_r;
  wire [11:0] sarKeep  = cmpHigh ? sar_r : (sar_r & ~bitMask);
  wire        lastStep = bit_r == 4'd12 - nBits;
  // Result aligned to the chosen resolution
  // Bits below the chosen resolution are never tried, so shifting loses nothing
  wire [11:0] result   = sarKeep >> (4'd12 - nBits);
  wire        outWin   = result < winLo_r || result > winHi_r;
  wire        convDone = busy && tick && state_r == SADC_CONV && lastStep;
  wire        seqEnd   = nextCh[5];

  // Clamp a sampling setting to the legal range
  function automatic logic [8:0] sadc_clamp(input logic [8:0] v);
    logic [8:0] res;
    res = v;
    if (v < 9'(SADC_SMP_MIN)) begin
      res = 9'(SADC_SMP_MIN);
    end else if (v > 9'(SADC_SMP_MAX)) begin
      res = 9'(SADC_SMP_MAX);
    end
    return res;
  endfunction : sadc_clamp

  // Sampling writes saturate at the legal range instead of wrapping
  wire [8:0]  smpFastIn = sadc_clamp(regWdata[8:0]); // R6
  wire [8:0]  smpSlowIn = sadc_clamp(regWdata[24:16]); // R6

  // Read multiplexer
  // Unmapped addresses read zero; status reports busy beside the flags
  wire [31:0] rdMux =
      regAddr == SADC_CTRL_OFS   ? ctrl_r :
      regAddr == SADC_SMP_OFS    ? {7'h00, smpSlow_r, 7'h00, smpFast_r} :
      regAddr == SADC_CHSEL_OFS  ? {5'h00, chSel_r} :
      regAddr == SADC_SLOW_OFS   ? {5'h00, slowGrp_r} :
      regAddr == SADC_WIN_OFS    ? {4'h0, winHi_r, 4'h0, winLo_r} :
      regAddr == SADC_STAT_OFS   ? {28'h000_0000, busy, flags_r} :
      regAddr == SADC_DATA_OFS   ? {20'h0_0000, data_r} :
      regAddr == SADC_BUFDIS_OFS ? {7'h00, bufDis_r} : 32'h0000_0000;

  // Event sets for this cycle
  // Scan runs flag the end only after their last channel; a lone conversion
  // always ends its sequence, so seqEnd covers both
  wire        setEoc = convDone && seqEnd; // R15 R22
  wire        setWin = convDone && ctrl_r[SADC_CTRL_WINEN]
                       && ch_r == winCh && outWin; // R14
  // A take in the same cycle as the new result means the old one was read
  wire        setOvr = convDone && unread_r && ~dmaAck && ~dmaDis; // R16
  wire [2:0]  clrMsk = wrStat ? regWdata[2:0] : 3'b000;
  wire [2:0]  setMsk = {setOvr, setWin, setEoc};
  // Next flags; the interrupt follows them with no extra cycle of delay
  wire [2:0]  flags_nxt = (flags_r & ~clrMsk) | setMsk; // R26
  wire [2:0]  irqEnMsk  = {ctrl_r[SADC_CTRL_OVRIE], ctrl_r[SADC_CTRL_WINIE],
                           ctrl_r[SADC_CTRL_EOCIE]};
  // A DMA take that meets a new result still leaves the new one unread
  wire        unread_nxt = convDone ? ~dmaDis : (unread_r & ~dmaAck);
  wire        dmaReq_nxt = convDone ? ~dmaDis : (dmaReq_r & ~dmaAck); // R17

  // Register writes; start bit is self-clearing
  // Status clears go through the flag logic, so no case item for them
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r    <= 32'h0000_0000; // R11
      smpFast_r <= SADC_SMP_RST;
      smpSlow_r <= SADC_SMP_RST;
      chSel_r   <= 27'h000_0000;
      slowGrp_r <= 27'h000_0000;
      winLo_r   <= 12'h000;
      winHi_r   <= 12'hFFF;
      bufDis_r  <= 25'h000_0000;
    end else if (clkEn && regWr) begin
      unique case (regAddr)
        SADC_CTRL_OFS:   ctrl_r <= regWdata & ~(32'h0000_0001 << SADC_CTRL_START);
        SADC_SMP_OFS: begin
          smpFast_r <= smpFastIn; // R6
          smpSlow_r <= smpSlowIn; // R12
        end
        SADC_CHSEL_OFS:  chSel_r <= regWdata[26:0];
        SADC_SLOW_OFS:   slowGrp_r <= regWdata[26:0];
        SADC_WIN_OFS:    {winHi_r, winLo_r} <= {regWdata[27:16], regWdata[11:0]};
        SADC_BUFDIS_OFS: bufDis_r <= regWdata[24:0]; // R10
        default: ;
      endcase
    end
  end

  // Sticky flags: a set in the same cycle beats the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_r <= 3'b000;
    end else if (clkEn) begin
      flags_r <= flags_nxt; // R26
    end
  end

  // Trigger input conditioning and divider
  // Only the second stage onwards is read, so a metastable first stage stays contained
  always_ff @(posedge clk) begin
    if (rst) begin
      pinSync_r <= 3'b000;
      pinLvl_r  <= 1'b0;
      tmrPrev_r <= 1'b0;
      divTick_r <= 1'b0;
    end else if (clkEn) begin
      pinSync_r <= {pinSync_r[1:0], trigPin};
      if (pinStable) begin
        pinLvl_r <= pinSync_r[2];
      end
      tmrPrev_r <= timerTrig;
      divTick_r <= ~divTick_r & ~divHold; // R4
    end
  end

  // Sequencer: sample, approximate, move to next channel or stop
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= SADC_IDLE;
      ch_r    <= 5'h00;
      cnt_r   <= 9'h000;
      bit_r   <= 4'h0;
      sar_r   <= 12'h000;
    end else if (clkEn) begin
      unique case (state_r)
        SADC_IDLE: begin
          // New triggers only count here; while busy they are dropped
          if (convOn && trigAny && ~firstCh[5]) begin // R25 R18
            ch_r    <= firstCh[4:0];
            cnt_r   <= 9'h000;
            state_r <= SADC_SAMPLE;
          end
        end
        // Counts converter ticks, not system cycles
        SADC_SAMPLE: begin
          if (tick) begin
            if (cnt_r == smpLen - 9'd1) begin // R6
              bit_r   <= 4'd11; // R2
              sar_r   <= 12'h800;
              state_r <= SADC_CONV;
            end else begin
              cnt_r <= cnt_r + 9'd1;
            end
          end
        end
        SADC_CONV: begin
          if (tick) begin // R5
            if (lastStep) begin // R1
              sar_r   <= sarKeep;
              state_r <= SADC_NEXT;
            end else begin
              sar_r   <= sarKeep | (bitMask >> 1);
              bit_r   <= bit_r - 4'd1;
            end
          end
        end
        // Clearing the on bit abandons the run at the next channel boundary
        SADC_NEXT: begin
          cnt_r <= 9'h000;
          if (~convOn || oneShot) begin
            state_r <= SADC_IDLE;
          end else if (~seqEnd) begin // R20
            ch_r    <= nextCh[4:0];
            state_r <= SADC_SAMPLE;
          end else if (contEn && ~restart[5]) begin // R19 R23
            ch_r    <= restart[4:0];
            state_r <= SADC_SAMPLE;
          end else begin
            state_r <= SADC_IDLE;
          end
        end
      endcase
    end
  end

  // Result register, DMA request and outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      data_r     <= 12'h000;
      unread_r   <= 1'b0;
      dmaReq_r   <= 1'b0;
      irq_r      <= 1'b0;
      sampleOn_r <= 1'b0;
      rdata_r    <= 32'h0000_0000;
    end else if (clkEn) begin
      if (convDone) begin
        data_r <= result; // R27 R15
      end
      unread_r   <= unread_nxt;
      dmaReq_r   <= dmaReq_nxt; // R17
      irq_r      <= |(flags_nxt & irqEnMsk); // R26 R14
      sampleOn_r <= state_r == SADC_SAMPLE;
      rdata_r    <= regRd ? rdMux : 32'h0000_0000;
    end
  end

  // Analog-facing outputs come from registers
  // Source enables reach the analog side straight from the control word
  assign regRdata      = rdata_r;
  assign muxSel        = ch_r;
  assign sampleOn      = sampleOn_r;
  assign dacCode       = sar_r;
  assign vrefEnable    = ctrl_r[SADC_CTRL_VREFEN];
  assign tempEnable    = ctrl_r[SADC_CTRL_TSEN];
  assign pinBufDisable = bufDis_r;
  assign dmaReq        = dmaReq_r;
  assign irq           = irq_r;

endmodule : sadc_sequencer

`default_nettype wire

// ===== test/sadc_seq_properties.sv
/*
  Concurrent checks on the converter sequencer's ports.
  Assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none

module sadc_seq_properties
  import sadc_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register port
  input wire logic [7:0]  regAddr,
  input wire logic        regWr,
  // Front end, DMA and interrupt
  input wire logic [4:0]  muxSel,
  input wire logic        sampleOn,
  input wire logic        vrefEnable,
  input wire logic [24:0] pinBufDisable,
  input wire logic        dmaReq,
  input wire logic        dmaAck,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [9:0] smpRun_r;

  // Run length of sampling; saturates so a stuck phase still trips the bound
  always_ff @(posedge clk) begin
    if (rst || !sampleOn) smpRun_r <= 10'h000;
    else if (smpRun_r != 10'h3FF) smpRun_r <= smpRun_r + 10'h001;
  end

  smp_min_len_a: assert property ($rose(sampleOn) |=> sampleOn [*3])
    else $error("sampling shorter than four cycles");
  smp_max_len_a: assert property (smpRun_r <= 10'h300)
    else $error("sampling longer than the slowest setting");
  mux_hold_a: assert property (sampleOn && $past(sampleOn) |-> $stable(muxSel))
    else $error("channel moved while sampling");
  mux_range_a: assert property (muxSel <= 5'h1A)
    else $error("channel beyond the internal inputs");
  dma_hold_a: assert property (dmaReq && !dmaAck |=> dmaReq)
    else $error("request withdrawn before it was taken");
  dma_drop_a: assert property ($fell(dmaReq) |-> $past(dmaAck))
    else $error("request dropped without a take");
  vref_write_a: assert property (!$stable(vrefEnable) |-> $past(regWr && regAddr == SADC_CTRL_OFS))
    else $error("reference enable moved without a control write");
  buf_write_a: assert property (!$stable(pinBufDisable) |-> $past(regWr && regAddr == SADC_BUFDIS_OFS))
    else $error("buffer disable moved without a write");
  irq_clear_a: assert property ($fell(irq) |-> $past(regWr) || $past(regWr, 2))
    else $error("interrupt fell without a software write");
endmodule : sadc_seq_properties

`default_nettype wire

// ===== test/sadc_front_model.sv
/*
  Far-side model: comparator over fixed per-channel levels and a DMA
  engine that takes each result four cycles after the request.
  Assumes the sequencer's clock and reset; stall holds the DMA off.
*/
`timescale 1ns/1ns
`default_nettype none

module sadc_front_model
  import sadc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Converter side
  input  wire logic [4:0]  muxSel,
  input  wire logic [11:0] dacCode,
  output logic             cmpHigh,
  // DMA side
  input  wire logic        dmaReq,
  input  wire logic        stall,
  output logic             dmaAck,
  output int               ackCount
);
  logic [1:0] wait_r;

  // Distinct level per channel so a wrong channel shows in the data
  function automatic logic [11:0] level(input logic [4:0] ch);
    return 12'h0A7 + 12'(ch) * 12'h093;
  endfunction : level

  // Comparator answers in the same cycle as the trial code
  assign cmpHigh = level(muxSel) >= dacCode;

  // Slow taker; a stalled engine leaves the result unread
  always_ff @(posedge clk) begin
    dmaAck <= 1'b0;
    if (rst) begin
      wait_r   <= 2'h0;
      ackCount <= 0;
    end else if (dmaReq && !dmaAck && !stall) begin
      wait_r <= wait_r + 2'h1;
      if (wait_r == 2'h3) begin
        dmaAck   <= 1'b1;
        ackCount <= ackCount + 1;
      end
    end
  end
endmodule : sadc_front_model

`default_nettype wire

// ===== test/test_sadc_sequencer.sv
/*
  Self-checking bench for the sequencer: single, triggered, scan, overrun
  and continuous runs; register reads are checked through a note queue.
  Assumes the package, front-end model and properties compile first.
*/
`timescale 1ns/1ns
`default_nettype none

module test_sadc_sequencer
  import sadc_pkg::*;
();
  logic        clk, rst, clkEn, regWr, regRd, timerTrig, trigPin, cmpHigh, stall;
  logic        sampleOn, vrefEnable, tempEnable, dmaReq, dmaAck, irq, rdLate, smpPrev;
  logic [7:0]  regAddr;
  logic [4:0]  muxSel, ch;
  logic [11:0] dacCode;
  logic [24:0] pinBufDisable;
  logic [31:0] regWdata, regRdata, ctrl, expNote, mskNote;
  logic [31:0] expQ[$], mskQ[$];
  int          fail_count, cmp_count, smpLen, ackCount, a0, n;

  sadc_sequencer u_dut (.clk(clk), .rst(rst), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .timerTrig(timerTrig), .trigPin(trigPin), .cmpHigh(cmpHigh), .muxSel(muxSel),
    .sampleOn(sampleOn), .dacCode(dacCode), .vrefEnable(vrefEnable),
    .tempEnable(tempEnable), .pinBufDisable(pinBufDisable), .dmaReq(dmaReq),
    .dmaAck(dmaAck), .irq(irq));
  sadc_front_model u_front (.clk(clk), .rst(rst), .muxSel(muxSel), .dacCode(dacCode),
    .cmpHigh(cmpHigh), .dmaReq(dmaReq), .stall(stall), .dmaAck(dmaAck),
    .ackCount(ackCount));

  always #10 clk = ~clk;

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Accesses keep a gap cycle so a strobe is never lowered and raised at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
  endtask : rd

  task automatic waitIrq();
    for (n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge clk);
    if (irq !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t no end of conversion", $time);
      report_and_stop();
    end
  endtask : waitIrq

  task automatic fire(input int src);
    if (src == 0) wr(SADC_CTRL_OFS, ctrl | (1 << SADC_CTRL_START));
    else if (src == 1) begin
      timerTrig <= 1'b1;
      @(posedge clk);
      timerTrig <= 1'b0;
      @(posedge clk);
    end else trigPin <= ~trigPin;
  endtask : fire

  // Read data stand only in the cycle after the strobe; the note is taken then
  always @(posedge clk) begin
    if (rdLate) begin
      expNote = expQ.pop_front();
      mskNote = mskQ.pop_front();
      chk(regRdata & mskNote, expNote);
    end
    rdLate  <= regRd;
    smpLen  <= (sampleOn && !smpPrev) ? 1 : smpLen + int'(sampleOn);
    smpPrev <= sampleOn;
  end

  initial begin
    {clk, clkEn, regWr, regRd, timerTrig, trigPin, stall, rdLate, smpPrev} = '0;
    rst = 1'b1;
    clkEn = 1'b1;
    {regAddr, regWdata, fail_count, cmp_count, smpLen} = '0;
    void'($urandom(32'h57f3));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(SADC_CTRL_OFS, 32'h0000_0000, '1);
    rd(SADC_SMP_OFS, 32'h0004_0004, '1);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000, '1);
    ctrl = $urandom & 32'h01FF_FFFF;
    wr(SADC_BUFDIS_OFS, ctrl);
    rd(SADC_BUFDIS_OFS, ctrl, '1);
    chk(32'(pinBufDisable), ctrl);
    wr(SADC_WIN_OFS, 32'h0000_0000);
    wr(SADC_CTRL_OFS, 32'h0000_0001);
    repeat (SADC_STAB_CYC) @(posedge clk);
    // Each pass: new resolution, trigger source and sampling group; divider on in the last two
    for (int i = 0; i < 4; i++) begin
      ch = 5'($urandom % 25);
      wr(SADC_SMP_OFS, ((10 + i) << 16) | (4 + i));
      wr(SADC_SLOW_OFS, (i % 2) << ch);
      wr(SADC_CHSEL_OFS, (1 << ch) | 1);
      ctrl = 1 | (1 << SADC_CTRL_DMADIS) | (1 << SADC_CTRL_EOCIE) | (i << SADC_CTRL_RES)
           | ((i % 3) << SADC_CTRL_TRIG) | ((i / 2) << SADC_CTRL_DIV2)
           | ((i % 2) << SADC_CTRL_WINEN) | (ch << SADC_CTRL_WINCH);
      wr(SADC_CTRL_OFS, ctrl);
      fire(i % 3);
      if (i % 3 == 0) wr(SADC_CTRL_OFS, ctrl | (1 << SADC_CTRL_START));
      waitIrq();
      chk(smpLen, ((i % 2) ? 10 + i : 4 + i) * (i / 2 + 1));
      rd(SADC_DATA_OFS, 32'(u_front.level(ch)) >> (2 * i), '1);
      rd(SADC_STAT_OFS, (i % 2) * 2 + 1, 32'h0000_0007);
      wr(SADC_STAT_OFS, 32'h0000_0007);
      repeat (2) @(posedge clk);
      chk(irq, 0);
      chk(sampleOn, 0);
    end
    // Scan of two pins and the reference; the sensor is selected but left off
    wr(SADC_CHSEL_OFS, 32'h0600_0024);
    ctrl = 32'h0000_1201;
    wr(SADC_CTRL_OFS, ctrl);
    chk(vrefEnable, 1);
    chk(tempEnable, 0);
    a0 = ackCount;
    fire(0);
    waitIrq();
    rd(SADC_DATA_OFS, 32'(u_front.level(5'h19)), '1);
    rd(SADC_STAT_OFS, 32'h0000_0001, 32'h0000_0007);
    repeat (8) @(posedge clk);
    chk(ackCount - a0, 3);
    wr(SADC_STAT_OFS, 32'h0000_0007);
    stall <= 1'b1;
    fire(0);
    waitIrq();
    rd(SADC_STAT_OFS, 32'h0000_0005, 32'h0000_0007);
    stall <= 1'b0;
    wr(SADC_STAT_OFS, 32'h0000_0007);
    repeat (10) @(posedge clk);
    a0 = ackCount;
    ctrl = ctrl | (1 << SADC_CTRL_CONTINUOUS_ENABLE);
    wr(SADC_CTRL_OFS, ctrl);
    fire(0);
    repeat (200) @(posedge clk);
    ctrl = 32'h0000_1201;
    wr(SADC_CTRL_OFS, ctrl);
    repeat (300) @(posedge clk);
    chk(sampleOn, 0);
    chk((ackCount - a0) % 3 == 0 && ackCount - a0 >= 6, 1);
    rd(SADC_STAT_OFS, 32'h0000_0001, 32'h0000_0005);
    // Let the last read note be compared before the verdict
    repeat (2) @(posedge clk);
    if (expQ.size() != 0) begin
      fail_count++;
      $display("[ERR] %0t read notes left unchecked", $time);
    end
    report_and_stop();
  end
endmodule : test_sadc_sequencer

bind sadc_sequencer sadc_seq_properties u_props (.clk(clk), .rst(rst), .regAddr(regAddr),
  .regWr(regWr), .muxSel(muxSel), .sampleOn(sampleOn), .vrefEnable(vrefEnable),
  .pinBufDisable(pinBufDisable), .dmaReq(dmaReq), .dmaAck(dmaAck), .irq(irq));

`default_nettype wire
